//--- dv/ltct_timer_sva.sv
`timescale 1ns/1ps

module ltct_timer_sva (
  input wire logic                    mclk,              // Oscillator clock
  input wire logic                    rst_n,             // Synchronous reset, active low
  input wire ltct_pkg::ltct_bus_req_t bus_req,           // Register port request
  input wire logic [7:0]              bus_rdata,         // Read data
  input wire logic                    capture_input_pin, // Capture pin
  input wire logic                    halt_mode,         // Deepest halt
  input wire ltct_pkg::ltct_irq_t     irq                // Interrupt requests
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Decoded accesses; writes that may clear an enable must lift the hold checks
  logic rd_s, rd_b, rd_c, wr_s, wr_b;
  assign rd_s = bus_req.rd && bus_req.addr == ltct_pkg::ADDR_TB2_CSR;
  assign rd_b = bus_req.rd && bus_req.addr == ltct_pkg::ADDR_CSR;
  assign rd_c = bus_req.rd && bus_req.addr == ltct_pkg::ADDR_CAPTURE;
  assign wr_s = bus_req.wr && bus_req.addr == ltct_pkg::ADDR_TB2_CSR;
  assign wr_b = bus_req.wr && bus_req.addr == ltct_pkg::ADDR_CSR;
  ////////////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_reload_back: assert property (bus_req.rd && bus_req.addr == ltct_pkg::ADDR_RELOAD
    && $past(bus_req.wr && bus_req.addr == ltct_pkg::ADDR_RELOAD, 2) && !$past(bus_req.wr)
    |=> bus_rdata == $past(bus_req.wdata, 3)) else $error("reload readback differs from write");
  chk_unmapped_zero: assert property (bus_req.rd && (bus_req.addr < 8'h08 || bus_req.addr > 8'h0C)
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  chk_tb1_hold: assert property (irq.timebase1 && !rd_b && !wr_b |=> irq.timebase1)
    else $error("timebase1 request dropped without its read");
  chk_tb2_hold: assert property (irq.timebase2 && !rd_s && !wr_s |=> irq.timebase2)
    else $error("timebase2 request dropped without its read");
  chk_cap_hold: assert property (irq.capture && !rd_c && !wr_b |=> irq.capture)
    else $error("capture request dropped without capture read");
  chk_tb1_match: assert property (rd_b |=> $past(irq.timebase1) == (bus_rdata[3] & bus_rdata[4]))
    else $error("timebase1 request not flag and enable");
  chk_tb2_match: assert property (rd_s |=> $past(irq.timebase2) == (bus_rdata[1] & bus_rdata[0]))
    else $error("timebase2 request not flag and enable");
  chk_cap_match: assert property (rd_b |=> $past(irq.capture) == (bus_rdata[7] & bus_rdata[6]))
    else $error("capture request not flag and enable");
  cov_tb1: cover property (irq.timebase1);
  cov_tb2: cover property (irq.timebase2);
  cov_cap: cover property (irq.capture);
endmodule : ltct_timer_sva

bind ltct_timer ltct_timer_sva chk_u (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .capture_input_pin(capture_input_pin), .halt_mode(halt_mode), .irq(irq));

//--- dv/ltct_timer_tb.sv
`timescale 1ns/1ps

module ltct_timer_tb;
  logic                    mclk = 1'b0, rst_n = 1'b0, pin = 1'b0, halt = 1'b0;
  ltct_pkg::ltct_bus_req_t req  = '0;
  logic [7:0]              rdata, v, w;
  ltct_pkg::ltct_irq_t     irq;
  int                      miscompares = 0, total_checks = 0, cyc = 0, t0, k, n;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle count used to space capture edges exactly
  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  ltct_timer dut_u (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
    .capture_input_pin(pin), .halt_mode(halt), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // Expected values worked out from the rules and the package constants
  function automatic int tb2_period(input logic [7:0] rl);
    return (int'(ltct_pkg::COUNT2_TOP) + 1 - int'(rl)) * ltct_pkg::PRESCALE_DIV;
  endfunction : tb2_period
  function automatic logic [7:0] cap_after(input logic [7:0] first, input int ticks);
    return 8'((int'(first) + ticks) % (int'(ltct_pkg::COUNT1_WRAP) + 1));
  endfunction : cap_after
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // One-cycle strobes, changed only right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Bounded wait for one request line; a hang is reported, not waited out
  task automatic wait_irq(input int b, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1 c++;
    end while (irq[b] !== 1'b1 && c < 20000);
    if (c >= 20000) begin
      chk("irq wait", 16'h0000, 16'h0001);
      close_out();
    end
  endtask : wait_irq
  // Rise to rise; the clearing read in between takes two edges
  task automatic period(input int b, input logic [7:0] a, input int exp);
    rd(a, v);
    wait_irq(b, n);
    rd(a, v);
    wait_irq(b, n);
    chk("period", 16'(n + 2), 16'(exp));
  endtask : period
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    k = $urandom(32'hA511E306);
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, with an ignored write to an unmapped offset
    wr(8'h0D, 8'($urandom));
    for (int a = 8; a < 14; a++) begin
      rd(8'(a), v);
      chk("reset value", 16'(v), 16'h0000);
    end
    $display("test reset done");
    // Reload readback; count ignores writes and stands still in halt
    w = 8'($urandom);
    wr(ltct_pkg::ADDR_RELOAD, w);
    rd(ltct_pkg::ADDR_RELOAD, v);
    chk("reload", 16'(v), 16'(w));
    @(posedge mclk) halt <= 1'b1;
    rd(ltct_pkg::ADDR_COUNT2, v);
    wr(ltct_pkg::ADDR_COUNT2, ~v);
    repeat (40) @(posedge mclk);
    rd(ltct_pkg::ADDR_COUNT2, w);
    chk("count frozen", 16'(w), 16'(v));
    @(posedge mclk) halt <= 1'b0;
    $display("test registers done");
    // Counter two: random reload, overflow period, reload value, flag clear
    w = 8'hC0 + 8'($urandom % 62);
    wr(ltct_pkg::ADDR_RELOAD, w);
    wr(ltct_pkg::ADDR_TB2_CSR, 8'h03);
    period(1, ltct_pkg::ADDR_TB2_CSR, tb2_period(w));
    rd(ltct_pkg::ADDR_COUNT2, v);
    chk("count after reload", 16'(v), 16'(w));
    rd(ltct_pkg::ADDR_TB2_CSR, v);
    chk("tb2 status", 16'(v), 16'h0003);
    chk("tb2 irq cleared", 16'(irq.timebase2), 16'h0000);
    $display("test counter two done");
    // Counter one at both periods; flag writes are ignored
    for (int s = 0; s < 2; s++) begin
      wr(ltct_pkg::ADDR_CSR, 8'h18 | 8'(s << 5));
      period(2, ltct_pkg::ADDR_CSR, (s == 0) ? ltct_pkg::TB_SHORT_OSC : ltct_pkg::TB_LONG_OSC);
    end
    rd(ltct_pkg::ADDR_CSR, v);
    chk("tb1 status", 16'(v), 16'h0038);
    rd(ltct_pkg::ADDR_CSR, v);
    chk("tb1 read clear", 16'(v), 16'h0030);
    $display("test counter one done");
    // Capture, masking, an inhibited second edge, then a capture a known tick count later
    wr(ltct_pkg::ADDR_CSR, 8'h80);
    rd(ltct_pkg::ADDR_CAPTURE, v);
    @(posedge mclk) pin <= ~pin;
    t0 = cyc;
    repeat (100) @(posedge mclk);
    #1 chk("capture irq", 16'(irq.capture), 16'h0001);
    wr(ltct_pkg::ADDR_CSR, 8'h00);
    #1 chk("capture irq masked", 16'(irq.capture), 16'h0000);
    wr(ltct_pkg::ADDR_CSR, 8'h80);
    #1 chk("capture flag kept", 16'(irq.capture), 16'h0001);
    @(posedge mclk) pin <= ~pin;
    repeat (8) @(posedge mclk);
    rd(ltct_pkg::ADDR_CAPTURE, v);
    rd(ltct_pkg::ADDR_CSR, w);
    chk("capture flag clear", 16'(w & 8'hF0), 16'h0080);
    k = 8 + $urandom % 30;
    // Bounded wait to the edge exactly k prescaler periods after the first capture edge
    for (n = 0; n < 2000 && cyc != t0 + ltct_pkg::PRESCALE_DIV * k; n++) @(posedge mclk);
    if (n >= 2000) begin
      chk("capture spacing", 16'h0000, 16'h0001);
      close_out();
    end
    pin <= ~pin;
    repeat (8) @(posedge mclk);
    rd(ltct_pkg::ADDR_CAPTURE, w);
    chk("capture value", 16'(w), 16'(cap_after(v, k)));
    $display("test capture done");
    close_out();
  end
endmodule : ltct_timer_tb

//--- shared/ltct_pkg.sv
package ltct_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_TB2_CSR = 8'h08;
  localparam logic [7:0] ADDR_RELOAD  = 8'h09;
  localparam logic [7:0] ADDR_COUNT2  = 8'h0A;
  localparam logic [7:0] ADDR_CSR     = 8'h0B;
  localparam logic [7:0] ADDR_CAPTURE = 8'h0C;

  // Field positions, timebase2_ctrl_status
  localparam int TB2_IE_BIT   = 1;
  localparam int TB2_FLAG_BIT = 0;

  // Field positions, timer_ctrl_status
  localparam int CAP_IE_BIT   = 7;
  localparam int CAP_FLAG_BIT = 6;
  localparam int TB_SEL_BIT   = 5;
  localparam int TB1_IE_BIT   = 4;
  localparam int TB1_FLAG_BIT = 3;

  // Reset values
  localparam logic [7:0] RELOAD_RST  = 8'h00;
  localparam logic [7:0] COUNT2_RST  = 8'h00;
  localparam logic [7:0] CAPTURE_RST = 8'h00;
  localparam logic [7:0] COUNT1_RST  = 8'h00;

  // Timing: mclk is the oscillator; counters tick at the oscillator divided by the prescaler
  localparam int         PRESCALE_DIV = 32;
  localparam int         TB_SHORT_OSC = 8000;
  localparam int         TB_LONG_OSC  = 16000;
  localparam logic [4:0] PRESC_LAST   = 5'(PRESCALE_DIV - 1);
  localparam logic [7:0] COUNT1_WRAP  = 8'(TB_SHORT_OSC / PRESCALE_DIV - 1);
  localparam logic [7:0] COUNT2_TOP   = 8'hFF;

  // Register port request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ltct_bus_req_t;

  // Interrupt requests
  typedef struct packed {
    logic timebase1;
    logic timebase2;
    logic capture;
  } ltct_irq_t;

  // Whole state of the timer
  typedef struct packed {
    logic [4:0] presc;
    logic [7:0] count1;
    logic       half;
    logic [7:0] count2;
    logic [7:0] reload;
    logic       tb2_ie;
    logic       tb2_flag;
    logic       cap_ie;
    logic       cap_flag;
    logic       tb_sel;
    logic       tb1_ie;
    logic       tb1_flag;
    logic [7:0] capture;
    logic [1:0] pin_sync;
    logic       pin_prev;
    logic [2:0] warm;
    logic [7:0] rdata;
    ltct_irq_t  irq;
  } ltct_state_t;

endpackage : ltct_pkg

//--- src/ltct_timer.sv
// Operation
// - The reload register is 8-bit read/write, resets to zero, and is copied into counter two on each overflow.
// - Counter two's current value is readable at a read-only register that resets to zero and ignores writes.
// - Bit 7 of the main control/status register enables the capture interrupt and is freely written by software.
// - Bit 6 of the main control/status register is set on capture, cleared only by reading the capture register.
// - Bit 5 of the main control/status register selects an 8000 or 16000 oscillator-period timebase.
// - Bit 4 of the main control/status register enables the counter-one timebase interrupt.
// - Bit 3 of the main control/status register is set at each timebase period end (every other counter-one overflow when bit 5 is set) and cleared by reading it.
// - While the capture flag is clear, either edge on the capture pin latches counter one into the capture register.
// - The capture register is cleared to zero by reset.
// - Registers sit at 08 (counter-two status), 09 (reload), 0A (count), 0B (main status), 0C (capture).
// - Counter one counts from zero at oscillator/32, overflows when wrapping F9h to 00h, and is not accessible.
// - Counter two counts at oscillator/32 and on passing FFh reloads from the reload register.
// - The counter-two status register holds an interrupt enable in bit 1 and a read-cleared overflow flag in bit 0.
// - All counting stops in the deepest halt mode; other low power modes leave the timer running.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

module ltct_timer (
  input  wire logic                   mclk,              // Oscillator clock, 100 MHz
  input  wire logic                   rst_n,             // Synchronous reset, active low
  input  wire ltct_pkg::ltct_bus_req_t bus_req,          // Register port request
  output logic [7:0]                  bus_rdata,         // Read data, cycle after the read strobe
  input  wire logic                   capture_input_pin, // Asynchronous capture pin
  input  wire logic                   halt_mode,         // Deepest halt mode, same clock domain
  output ltct_pkg::ltct_irq_t         irq                // Interrupt requests
);

  ltct_pkg::ltct_state_t q;
  ltct_pkg::ltct_state_t d;

  logic tick;
  logic tb1_event;
  logic tb2_event;
  logic pin_edge;
  logic rd_csr;
  logic rd_tb2;
  logic rd_cap;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  // Prescaler tick; halting freezes the prescaler and so every counter
  assign tick      = (q.presc == ltct_pkg::PRESC_LAST) && !halt_mode;
  // Long period drops every other wrap, so both periods share the same wrap point
  assign tb1_event = tick && (q.count1 == ltct_pkg::COUNT1_WRAP) && (!q.tb_sel || q.half);
  assign tb2_event = tick && (q.count2 == ltct_pkg::COUNT2_TOP);
  // Edge only trusted once the synchroniser and the previous sample are filled
  assign pin_edge  = q.warm[2] && (q.pin_sync[1] != q.pin_prev);

  assign rd_csr = bus_req.rd && (bus_req.addr == ltct_pkg::ADDR_CSR);
  assign rd_tb2 = bus_req.rd && (bus_req.addr == ltct_pkg::ADDR_TB2_CSR);
  assign rd_cap = bus_req.rd && (bus_req.addr == ltct_pkg::ADDR_CAPTURE);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;

    // Pin synchroniser; first stage feeds only the second
    d.pin_sync = {q.pin_sync[0], capture_input_pin};
    d.pin_prev = q.pin_sync[1];
    d.warm     = {q.warm[1:0], 1'b1};

    // Prescaler, free running except in halt
    if (!halt_mode) begin
      d.presc = q.presc + 5'h01;
    end

    // Counter one, timebase
    if (tick) begin
      if (q.count1 == ltct_pkg::COUNT1_WRAP) begin
        d.count1 = ltct_pkg::COUNT1_RST;
        d.half   = !q.half;
      end else begin
        d.count1 = q.count1 + 8'h01;
      end
    end

    // Counter two, auto-reload
    if (tick) begin
      if (tb2_event) begin
        d.count2 = q.reload;
      end else begin
        d.count2 = q.count2 + 8'h01;
      end
    end

    // Software writes; flags and counts are never written
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ltct_pkg::ADDR_TB2_CSR: begin
          d.tb2_ie = bus_req.wdata[ltct_pkg::TB2_IE_BIT];
        end
        ltct_pkg::ADDR_RELOAD: begin
          d.reload = bus_req.wdata;
        end
        ltct_pkg::ADDR_CSR: begin
          d.cap_ie = bus_req.wdata[ltct_pkg::CAP_IE_BIT];
          d.tb_sel = bus_req.wdata[ltct_pkg::TB_SEL_BIT];
          d.tb1_ie = bus_req.wdata[ltct_pkg::TB1_IE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read-clears first, then hardware sets so a same-cycle event is kept
    if (rd_csr) begin
      d.tb1_flag = 1'b0;
    end
    if (rd_tb2) begin
      d.tb2_flag = 1'b0;
    end
    if (rd_cap) begin
      d.cap_flag = 1'b0;
    end
    if (tb1_event) begin
      d.tb1_flag = 1'b1;
    end
    if (tb2_event) begin
      d.tb2_flag = 1'b1;
    end
    // Inhibit uses the old flag, so an unread capture is never overwritten
    if (pin_edge && !q.cap_flag) begin
      d.capture  = q.count1;
      d.cap_flag = 1'b1;
    end

    // Read data, valid only in the cycle after the strobe
    d.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ltct_pkg::ADDR_TB2_CSR: begin
          d.rdata[ltct_pkg::TB2_IE_BIT]   = q.tb2_ie;
          d.rdata[ltct_pkg::TB2_FLAG_BIT] = q.tb2_flag;
        end
        ltct_pkg::ADDR_RELOAD: begin
          d.rdata = q.reload;
        end
        ltct_pkg::ADDR_COUNT2: begin
          d.rdata = q.count2;
        end
        ltct_pkg::ADDR_CSR: begin
          d.rdata[ltct_pkg::CAP_IE_BIT]   = q.cap_ie;
          d.rdata[ltct_pkg::CAP_FLAG_BIT] = q.cap_flag;
          d.rdata[ltct_pkg::TB_SEL_BIT]   = q.tb_sel;
          d.rdata[ltct_pkg::TB1_IE_BIT]   = q.tb1_ie;
          d.rdata[ltct_pkg::TB1_FLAG_BIT] = q.tb1_flag;
        end
        ltct_pkg::ADDR_CAPTURE: begin
          d.rdata = q.capture;
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // Requests follow the next flag and enable, so they drop with the clearing read
    d.irq.timebase1 = d.tb1_flag && d.tb1_ie;
    d.irq.timebase2 = d.tb2_flag && d.tb2_ie;
    d.irq.capture   = d.cap_flag && d.cap_ie;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Capture flag resets to a defined zero instead of the undefined value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q          <= '0;
      q.count1   <= ltct_pkg::COUNT1_RST;
      q.count2   <= ltct_pkg::COUNT2_RST;
      q.reload   <= ltct_pkg::RELOAD_RST;
      q.capture  <= ltct_pkg::CAPTURE_RST;
    end else begin
      q <= d;
    end
  end

  assign bus_rdata = q.rdata;
  assign irq       = q.irq;

endmodule : ltct_timer
